// >>> pkg/snd_pkg.sv
package snd_pkg;
  // opcodes that change lane usage
  localparam logic [7:0] OP_DUAL_OUT  = 8'h3B;
  localparam logic [7:0] OP_DUAL_IO   = 8'hBB;
  localparam logic [7:0] OP_QUAD_OUT  = 8'h6B;
  localparam logic [7:0] OP_QUAD_OUT4 = 8'h6C;
  localparam logic [7:0] OP_QUAD_IO   = 8'hEB;
  localparam logic [7:0] OP_QUAD_IO4  = 8'hEC;
  localparam logic [7:0] OP_QUAD_LD   = 8'h32;
  localparam logic [7:0] OP_QUAD_LD4  = 8'h34;
  // clocks of address plus dummy before the data phase
  localparam logic [5:0] WAIT_DUAL_OUT = 6'h18;
  localparam logic [5:0] WAIT_DUAL_IO  = 6'h0C;
  localparam logic [5:0] WAIT_QUAD_OUT = 6'h18;
  localparam logic [5:0] WAIT_QUAD_IO  = 6'h08;
  localparam logic [5:0] WAIT_QUAD_LD  = 6'h10;
  localparam logic [3:0] BYTE_BITS     = 4'h8;
  localparam logic [7:0] TX_RESET      = 8'hFF;

  typedef enum logic [1:0] {
    PH_OPC  = 2'b00,
    PH_ADR  = 2'b01,
    PH_DAT  = 2'b10,
    PH_IGN  = 2'b11
  } snd_phase_t;

  typedef struct packed {
    logic       opcode;
    logic [7:0] data;
  } snd_word_t;

  typedef struct packed {
    snd_phase_t phase;
    logic [2:0] adr_lanes;
    logic [2:0] dat_lanes;
    logic       out;
    logic       quad;
    logic [5:0] wait_clk;
  } snd_cmd_t;

  typedef struct packed {
    logic [3:0] out;
    logic [3:0] oe;
  } snd_pins_t;
endpackage

// >>> core/snd_front.sv
`timescale 1ns/10ps
module snd_front
  import snd_pkg::*;
(
  // system side
  input  wire logic       clock,
  input  wire logic       rst_b,
  // link clock and pins
  input  wire logic       spi_clk,
  input  wire logic       select_bar,
  input  wire logic [3:0] lane_in,
  output logic      [3:0] lane_out,
  output logic      [3:0] lane_oe,
  // protection inputs
  input  wire logic       hw_guard_enable,
  input  wire logic [3:0] block_guard_bits,
  input  wire logic [1:0] status_guard_bits,
  // received words
  output snd_word_t       rx_word,
  output logic            rx_valid,
  // read data
  input  wire logic [7:0] tx_data,
  output logic            tx_taken,
  // status
  output logic            frame_active,
  output logic            quad_active,
  output logic            write_blocked,
  output logic            reg_write_blocked,
  output logic      [3:0] region_guard
);

  typedef struct packed {
    logic       sel_s1, sel_s2, armed;
    logic       wp_s1, wp_s2;
    logic       rxt_s1, rxt_s2, rxt_s3;
    logic       txt_s1, txt_s2, txt_s3;
    logic       quad_s1, quad_s2;
    logic [7:0] tx_hold;
    snd_word_t  rx_word;
    logic       rx_valid, tx_taken, frame_active, quad_active;
    logic       write_blocked, reg_write_blocked;
    logic [3:0] region_guard;
  } snd_sys_t;

  typedef struct packed {
    snd_phase_t phase;
    logic [2:0] lanes;
    logic [2:0] dat_lanes;
    logic       out;
    logic       quad;
    logic [5:0] cnt;
    logic [3:0] bits;
    logic [7:0] sr;
    logic       first;
    snd_word_t  rx;
    logic       rx_tog;
    logic       g_s1, g_s2;
  } snd_rise_t;

  typedef struct packed {
    logic       hold;
    logic [7:0] txsr;
    logic [3:0] left;
    logic       tx_tog;
    snd_pins_t  pins;
  } snd_fall_t;

  snd_sys_t  s, next_s;
  snd_rise_t r, next_r;
  snd_fall_t f, next_f;
  logic      frame_rst;

  function automatic snd_cmd_t decode(input logic [7:0] op, input logic guard);
    snd_cmd_t c;
    c = '{phase: PH_DAT, adr_lanes: 3'h1, dat_lanes: 3'h1, out: 1'b1,
          quad: 1'b0, wait_clk: 6'h00};
    case (op)
      OP_DUAL_OUT: begin
        c = '{PH_ADR, 3'h1, 3'h2, 1'b1, 1'b0, WAIT_DUAL_OUT};
      end
      OP_DUAL_IO: begin
        c = '{PH_ADR, 3'h2, 3'h2, 1'b1, 1'b0, WAIT_DUAL_IO};
      end
      OP_QUAD_OUT, OP_QUAD_OUT4: begin
        c = '{PH_ADR, 3'h1, 3'h4, 1'b1, 1'b1, WAIT_QUAD_OUT};
      end
      OP_QUAD_IO, OP_QUAD_IO4: begin
        c = '{PH_ADR, 3'h4, 3'h4, 1'b1, 1'b1, WAIT_QUAD_IO};
      end
      OP_QUAD_LD, OP_QUAD_LD4: begin
        c = '{PH_ADR, 3'h1, 3'h4, 1'b0, 1'b1, WAIT_QUAD_LD};
      end
      default: begin
        c.phase = PH_DAT;
      end
    endcase
    // quad commands are swallowed while hardware protection is on
    if (c.quad && guard) begin
      c = '{PH_IGN, 3'h1, 3'h1, 1'b0, 1'b0, 6'h00};
    end
    return c;
  endfunction

  // frame logic held reset while deselected or until select is first seen high after reset
  assign frame_rst = select_bar | ~s.armed;

  // ---------------- link, rising edge: sampling ----------------
  always_comb begin
    snd_cmd_t   c;
    logic [7:0] sh;
    logic [3:0] nb;
    sh     = r.sr;
    nb     = 4'h0;
    c      = decode(r.sr[6:0] == 7'h00 ? 8'h00 : 8'h00, 1'b0);
    next_r = r;
    next_r.g_s1 = hw_guard_enable;
    next_r.g_s2 = r.g_s1;
    case (r.lanes)
      3'h2:    sh = {r.sr[5:0], lane_in[1], lane_in[0]};
      3'h4:    sh = {r.sr[3:0], lane_in};
      default: sh = {r.sr[6:0], lane_in[0]};
    endcase
    nb = r.bits + {1'b0, r.lanes};
    // paused: clock and inputs ignored, state frozen; the live pause_n level
    // covers a change made while the clock was low as well as one made while high
    if ((lane_in[3] || r.quad) && r.phase != PH_IGN
        && !(r.phase == PH_DAT && r.out)) begin
      next_r.sr   = sh;
      next_r.bits = nb;
      if (nb == BYTE_BITS) begin
        next_r.bits   = 4'h0;
        next_r.rx     = '{opcode: r.first, data: sh};
        next_r.rx_tog = ~r.rx_tog;
        next_r.first  = 1'b0;
      end
      case (r.phase)
        PH_OPC: begin
          if (nb == BYTE_BITS) begin
            c = decode(sh, r.g_s2);
            next_r.phase     = c.phase;
            next_r.lanes     = c.phase == PH_DAT ? c.dat_lanes : c.adr_lanes;
            next_r.dat_lanes = c.dat_lanes;
            next_r.out       = c.out;
            next_r.quad      = c.quad;
            next_r.cnt       = c.wait_clk;
          end
        end
        PH_ADR: begin
          next_r.cnt = r.cnt - 6'h01;
          if (r.cnt == 6'h01) begin
            next_r.phase = PH_DAT;
            next_r.lanes = r.dat_lanes;
            next_r.bits  = 4'h0;
          end
        end
        default: begin
          next_r.phase = r.phase;
        end
      endcase
    end
  end

  always_ff @(posedge spi_clk or posedge frame_rst) begin
    if (frame_rst) begin
      r <= '{phase: PH_OPC, lanes: 3'h1, dat_lanes: 3'h1, out: 1'b0, quad: 1'b0,
             cnt: 6'h00, bits: 4'h0, sr: 8'h00, first: 1'b1, rx: '0,
             rx_tog: 1'b0, g_s1: 1'b0, g_s2: 1'b0};
    end else begin
      r <= next_r;
    end
  end

  // ---------------- link, falling edge: driving ----------------
  always_comb begin
    logic [7:0] cur;
    next_f = f;
    // falling clock edge makes a pending pause take effect or end
    next_f.hold = ~lane_in[3] & ~r.quad;
    cur = f.left == 4'h0 ? s.tx_hold : f.txsr;
    next_f.pins.oe = 4'h0;
    if (!next_f.hold && r.phase == PH_DAT && r.out) begin
      if (f.left == 4'h0) begin
        next_f.tx_tog = ~f.tx_tog;
      end
      case (r.lanes)
        3'h4: begin
          next_f.pins = '{out: cur[7:4], oe: 4'hF};
          next_f.txsr = {cur[3:0], 4'h0};
        end
        3'h2: begin
          next_f.pins = '{out: {2'b00, cur[7:6]}, oe: 4'h3};
          next_f.txsr = {cur[5:0], 2'b00};
        end
        default: begin
          next_f.pins = '{out: {2'b00, cur[7], 1'b0}, oe: 4'h2};
          next_f.txsr = {cur[6:0], 1'b0};
        end
      endcase
      next_f.left = (f.left == 4'h0 ? BYTE_BITS : f.left) - {1'b0, r.lanes};
    end else if (next_f.hold) begin
      next_f.pins.out = f.pins.out;
    end
  end

  always_ff @(negedge spi_clk or posedge frame_rst) begin
    if (frame_rst) begin
      f <= '{hold: 1'b0, txsr: 8'h00, left: 4'h0, tx_tog: 1'b0, pins: '0};
    end else begin
      f <= next_f;
    end
  end

  assign lane_out = f.pins.out;
  assign lane_oe  = f.pins.oe;

  // ---------------- system clock domain ----------------
  always_comb begin
    next_s = s;
    next_s.sel_s1  = select_bar;
    next_s.sel_s2  = s.sel_s1;
    next_s.wp_s1   = lane_in[2];
    next_s.wp_s2   = s.wp_s1;
    next_s.rxt_s1  = r.rx_tog;
    next_s.rxt_s2  = s.rxt_s1;
    next_s.rxt_s3  = s.rxt_s2;
    next_s.txt_s1  = f.tx_tog;
    next_s.txt_s2  = s.txt_s1;
    next_s.txt_s3  = s.txt_s2;
    next_s.quad_s1 = r.quad;
    next_s.quad_s2 = s.quad_s1;
    // a high select seen after reset arms the first frame
    if (s.sel_s2) begin
      next_s.armed = 1'b1;
    end
    // frame reset clears the link toggles; that edge arrives with select seen high
    // and is dropped. limitation: a byte ending just before select rises is lost
    next_s.rx_valid = (s.rxt_s2 ^ s.rxt_s3) & ~(s.sel_s1 | s.sel_s2);
    if ((s.rxt_s2 ^ s.rxt_s3) && !(s.sel_s1 || s.sel_s2)) begin
      next_s.rx_word = r.rx; // stable for a whole byte time
    end
    next_s.tx_taken = (s.txt_s2 ^ s.txt_s3) & ~(s.sel_s1 | s.sel_s2);
    // refill behind each byte taken; idle frames track the source
    if (s.sel_s2 || (s.txt_s2 ^ s.txt_s3)) begin
      next_s.tx_hold = tx_data;
    end
    next_s.frame_active = ~s.sel_s2 & s.armed;
    next_s.quad_active  = s.quad_s2;
    // lane2 carries data in quad, so write_blocked and reg_write_blocked are frozen then; region_guard still follows lane2
    next_s.write_blocked = s.quad_s2 ? s.write_blocked
                                     : hw_guard_enable & ~s.wp_s2;
    next_s.reg_write_blocked = s.quad_s2 ? s.reg_write_blocked
        : ~s.wp_s2 & (hw_guard_enable | (status_guard_bits != 2'b00));
    next_s.region_guard = (~s.wp_s2 && status_guard_bits != 2'b00)
                          ? block_guard_bits : 4'h0;
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s <= '{sel_s1: 1'b0, sel_s2: 1'b0, armed: 1'b0, wp_s1: 1'b1, wp_s2: 1'b1,
             rxt_s1: 1'b0, rxt_s2: 1'b0, rxt_s3: 1'b0, txt_s1: 1'b0,
             txt_s2: 1'b0, txt_s3: 1'b0, quad_s1: 1'b0, quad_s2: 1'b0,
             tx_hold: TX_RESET, rx_word: '0, rx_valid: 1'b0, tx_taken: 1'b0,
             frame_active: 1'b0, quad_active: 1'b0, write_blocked: 1'b0,
             reg_write_blocked: 1'b0, region_guard: 4'h0};
    end else begin
      s <= next_s;
    end
  end

  assign rx_word           = s.rx_word;
  assign rx_valid          = s.rx_valid;
  assign tx_taken          = s.tx_taken;
  assign frame_active      = s.frame_active;
  assign quad_active       = s.quad_active;
  assign write_blocked     = s.write_blocked;
  assign reg_write_blocked = s.reg_write_blocked;
  assign region_guard      = s.region_guard;

  // ---------------- checks ----------------
  deselect_float_a: assert property (@(posedge clock) disable iff (!rst_b)
    s.sel_s2 |-> lane_oe == 4'h0) else $error("lanes driven while deselected");

  opcode_end_a: assert property (@(posedge spi_clk) disable iff (frame_rst)
    (r.phase == PH_OPC && r.bits == 4'h7 && lane_in[3]) |=> r.phase != PH_OPC)
    else $error("opcode phase did not end after eight bits");

  quad_guard_a: assert property (@(posedge spi_clk) disable iff (frame_rst)
    $rose(r.quad) |-> !$past(r.g_s2)) else $error("quad started under guard");

  pause_float_a: assert property (@(negedge spi_clk) disable iff (frame_rst)
    f.hold |-> lane_oe == 4'h0) else $error("lane driven while paused");

  drive_phase_a: assert property (@(posedge spi_clk) disable iff (frame_rst)
    lane_oe != 4'h0 |-> (r.phase == PH_DAT && r.out))
    else $error("lane driven outside a read data phase");

  quad_no_pause_a: assert property (@(posedge spi_clk) disable iff (frame_rst)
    r.quad |-> !f.hold) else $error("pause taken during quad command");

  hw_block_a: assert property (@(posedge clock) disable iff (!rst_b)
    (hw_guard_enable && !s.wp_s2 && !s.quad_s2) |=> write_blocked)
    else $error("write not blocked by hardware guard");

  first_select_a: assert property (@(posedge clock) disable iff (!rst_b)
    !s.armed |-> ##1 !rx_valid [*2]) else $error("byte before first select edge");
endmodule

// >>> core/snd_front_unused.sv
`timescale 1ns/10ps

// >>> test/snd_host.sv
`timescale 1ns/10ps
module snd_host (
  // pins toward the device
  output logic       spi_clk,
  output logic       select_bar,
  output logic [3:0] h_out,
  output logic [3:0] h_oe,
  // resolved lane levels
  input  wire  logic [3:0] pin
);
  logic mode3 = 1'b0;
  initial begin
    spi_clk = 1'b0;
    select_bar = 1'b1;
    h_out = 4'hC;
    h_oe = 4'hD;
  end
  task automatic idle(input logic [3:0] d);
    h_out = d;
  endtask
  // odd offset keeps link edges off the system clock edges
  task automatic start(input logic m3);
    mode3 = m3;
    #7.3 spi_clk = m3;
    #20 select_bar = 1'b0;
    #20 spi_clk = 1'b0;
  endtask
  task automatic cyc(input logic [3:0] d, input logic [3:0] e, output logic [3:0] q);
    h_out = d;
    h_oe = e;
    #20 q = pin;
    spi_clk = 1'b1;
    #40 spi_clk = 1'b0;
    #20;
  endtask
  task automatic stop();
    #20 spi_clk = mode3;
    #20 select_bar = 1'b1;
    h_out = 4'hC;
    h_oe = 4'hD;
    #40;
  endtask
  task automatic send(input logic [7:0] b);
    logic [3:0] q;
    for (int i = 7; i >= 0; i--) begin
      cyc({3'b110, b[i]}, 4'hD, q);
    end
  endtask
endmodule

// >>> test/tb_serial_nand_spi_pin_interface.sv
`timescale 1ns/10ps
module tb_serial_nand_spi_pin_interface;
  import snd_pkg::*;
  logic       clock = 1'b0;
  logic       rst_b = 1'b0;
  logic       hw_guard_enable = 1'b0;
  logic       flip = 1'b0;
  logic [3:0] block_guard_bits = 4'h0;
  logic [1:0] status_guard_bits = 2'h0;
  logic [7:0] tx_data = 8'hC6;
  wire        spi_clk;
  wire        select_bar;
  wire  [3:0] h_out;
  wire  [3:0] h_oe;
  wire  [3:0] pin;
  logic [3:0] lane_out;
  logic [3:0] lane_oe;
  logic [3:0] region_guard;
  snd_word_t  rx_word;
  logic       rx_valid, tx_taken, frame_active, quad_active, write_blocked, reg_write_blocked;
  int         mismatches = 0;
  int         cmp_count = 0;
  int         tx_cnt = 0;
  snd_word_t  rxq[$];

  always #5 clock = ~clock;
  always @(posedge clock) flip <= ~flip;
  always @(posedge clock) if (rx_valid) rxq.push_back(rx_word);
  always @(posedge clock) if (tx_taken) tx_cnt++;
  // released lanes: pull-ups on 2 and 3, a changing level on 0 and 1
  assign pin = (lane_oe & lane_out) | (~lane_oe & h_oe & h_out)
             | (~lane_oe & ~h_oe & {2'b11, flip, ~flip});

  snd_host host (.spi_clk, .select_bar, .h_out, .h_oe, .pin);
  snd_front dut (.clock, .rst_b, .spi_clk, .select_bar, .lane_in(pin), .lane_out, .lane_oe,
    .hw_guard_enable, .block_guard_bits, .status_guard_bits, .rx_word, .rx_valid, .tx_data,
    .tx_taken, .frame_active, .quad_active, .write_blocked, .reg_write_blocked, .region_guard);

  task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wait_rx(input int n);
    for (int k = 0; k < 40 && rxq.size() < n; k++) @(negedge clock);
    if (rxq.size() < n) begin
      mismatches++;
      $display("[ERR] rx words expected %0d seen %0d", n, rxq.size());
      conclude();
    end
  endtask
  task automatic rd(input int n, output logic [7:0] b);
    logic [3:0] q;
    for (int c = 0; c < 8 / n; c++) begin
      host.cyc(4'hC, n == 1 ? 4'hD : n == 2 ? 4'hC : 4'h0, q);
      b = n == 1 ? {b[6:0], q[1]} : n == 2 ? {b[5:0], q[1:0]} : {b[3:0], q};
    end
  endtask

  task automatic t_boot();
    host.start(1'b0);
    repeat (10) @(negedge clock);
    rst_b = 1'b1;
    repeat (4) @(negedge clock);
    check("write_blocked reset", write_blocked, 1'b0);
    check("quad_active reset", quad_active, 1'b0);
    host.send(8'h05);
    check("lane_oe unarmed", lane_oe, 4'h0);
    host.stop();
    repeat (10) @(negedge clock);
    check("rx count", 16'(rxq.size()), 16'h0);
    $display("boot done");
  endtask
  task automatic t_single(input logic m3);
    logic [7:0] b;
    int         tx_base;
    @(negedge clock) tx_data = m3 ? 8'h3A : 8'hC6;
    tx_base = tx_cnt;
    host.start(m3);
    host.send(8'h05);
    check("frame_active", frame_active, 1'b1);
    for (int k = 0; k < 2; k++) begin
      rd(1, b);
      check("read byte", b, tx_data);
      check("lane_oe read", lane_oe, 4'h2);
    end
    host.stop();
    check("lane_oe idle", lane_oe, 4'h0);
    wait_rx(1);
    check("rx word", rxq[0], {1'b1, 8'h05});
    check("rx count", 16'(rxq.size()), 16'h1);
    rxq.delete();
    repeat (4) @(negedge clock);
    check("tx taken", 16'(tx_cnt - tx_base), 16'h3);
    check("frame_active idle", frame_active, 1'b0);
    $display("single mode %0d done", m3);
  endtask
  task automatic t_pause();
    logic [3:0] q;
    logic [7:0] b;
    host.start(1'b0);
    host.send(8'h05);
    for (int c = 0; c < 8; c++) begin
      host.cyc(c == 3 ? 4'h4 : 4'hC, 4'hD, q);
      b = {b[6:0], q[1]};
      if (c == 3) begin
        check("lane_oe paused", lane_oe, 4'h0);
        host.cyc(4'h5, 4'hD, q);
        host.cyc(4'hC, 4'hD, q);
      end
    end
    check("read byte", b, tx_data);
    host.stop();
    wait_rx(1);
    rxq.delete();
    $display("pause done");
  endtask
  task automatic t_rd(input logic [7:0] op, input int al, input int nc, input int dl,
                      input logic g);
    logic [3:0] q;
    logic [7:0] b;
    int         n;
    n = 1 + nc * al / 8 + int'(dl == 0);
    @(negedge clock) hw_guard_enable = g;
    tx_data = op ^ 8'h5C;
    host.start(1'b0);
    host.send(op);
    for (int c = 0; c < nc; c++) begin
      host.cyc(al == 1 ? {3'b110, c[0]} : al == 2 ? {2'b11, c[0], ~c[0]} : {2{c[0], ~c[0]}},
               al == 1 ? 4'hD : 4'hF, q);
      if (c == nc - 2) check("lane_oe addr", lane_oe, 4'h0);
    end
    if (dl == 0) begin
      host.cyc(4'h5, 4'hF, q);
      host.cyc(4'hA, 4'hF, q);
      check("lane_oe load", lane_oe, 4'h0);
    end else begin
      rd(dl, b);
      if (!g) check("read byte", b, tx_data);
      check("lane_oe read", lane_oe, g ? 4'h0 : dl == 2 ? 4'h3 : 4'hF);
    end
    check("quad_active", quad_active, !g && dl != 2);
    host.stop();
    check("lane_oe idle", lane_oe, 4'h0);
    wait_rx(g ? 1 : n);
    check("rx opcode", rxq[0], {1'b1, op});
    check("rx count", 16'(rxq.size()), 16'(g ? 1 : n));
    if (dl == 0) check("rx data", rxq[n - 1], 9'h05A);
    rxq.delete();
    $display("frame %h done", op);
  endtask
  task automatic t_guard();
    @(negedge clock);
    hw_guard_enable = 1'b1;
    block_guard_bits = 4'hA;
    host.idle(4'h8);
    repeat (6) @(negedge clock);
    check("write_blocked", write_blocked, 1'b1);
    check("region_guard", region_guard, 4'h0);
    status_guard_bits = 2'h1;
    hw_guard_enable = 1'b0;
    repeat (6) @(negedge clock);
    check("write_blocked", write_blocked, 1'b0);
    check("reg_write_blocked", reg_write_blocked, 1'b1);
    check("region_guard", region_guard, 4'hA);
    host.idle(4'hC);
    repeat (6) @(negedge clock);
    check("reg_write_blocked", reg_write_blocked, 1'b0);
    $display("guard done");
  endtask

  initial begin
    #600000;
    mismatches++;
    $display("[ERR] watchdog expected finish seen hang");
    conclude();
  end
  initial begin
    t_boot();
    t_single(1'b0);
    t_single(1'b1);
    t_pause();
    t_rd(OP_DUAL_OUT, 1, int'(WAIT_DUAL_OUT), 2, 1'b0);
    t_rd(OP_DUAL_IO, 2, int'(WAIT_DUAL_IO), 2, 1'b0);
    t_rd(OP_QUAD_OUT, 1, int'(WAIT_QUAD_OUT), 4, 1'b0);
    t_rd(OP_QUAD_OUT4, 1, int'(WAIT_QUAD_OUT), 4, 1'b0);
    t_rd(OP_QUAD_IO, 4, int'(WAIT_QUAD_IO), 4, 1'b0);
    t_rd(OP_QUAD_IO4, 4, int'(WAIT_QUAD_IO), 4, 1'b0);
    t_rd(OP_QUAD_LD, 1, int'(WAIT_QUAD_LD), 0, 1'b0);
    t_rd(OP_QUAD_LD4, 1, int'(WAIT_QUAD_LD), 0, 1'b0);
    t_rd(OP_QUAD_OUT, 1, int'(WAIT_QUAD_OUT), 4, 1'b1);
    t_guard();
    conclude();
  end
endmodule
